//--- hw/opcs_pkg.sv
// constants, field layouts and state type for the clock select block
package opcs_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_TRIM   = 8'h00;
    localparam logic [7:0] ADDR_FREQ   = 8'h04;
    localparam logic [7:0] ADDR_CFG    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // oscillator modes held in the configuration register
    typedef enum logic [2:0] {
        INTERNAL_DIRECT_MODE            = 3'h0,
        INTERNAL_CLKOUT_MODE            = 3'h1,
        INTERNAL_MULTIPLIED_MODE        = 3'h2,
        INTERNAL_MULTIPLIED_CLKOUT_MODE = 3'h3,
        CRYSTAL_MODE                    = 3'h4,
        CRYSTAL_MULTIPLIED_MODE         = 3'h5,
        EXTERNAL_CLOCK_IN_MODE          = 3'h6,
        EXT_CLOCK_MULTIPLIED_MODE       = 3'h7
    } opcs_mode_type;

    // configuration word: features, pll choice, prescaler, cpu divider, mode
    typedef struct packed {
        logic [3:0]    feature_enables;          // pwrt, fscm, wdt, two-speed
        logic          multiplier_config_enable; // cleared enables the pll
        logic          pll_choice_select;        // 0 fixed, 1 four-times
        logic [2:0]    pll_prescale_select;
        logic [1:0]    cpu_clock_divider_select;
        opcs_mode_type osc_mode;
    } opcs_cfg_type;

    // trim register layout
    typedef struct packed {
        logic       low_freq_source_select;
        logic       multiplier_soft_enable;
        logic [5:0] trim_value_field;
    } opcs_trim_type;

    // source clock edges seen as one-cycle ticks
    typedef struct packed {
        logic prim;  // first oscillator pin / crystal
        logic fast;  // 8 MHz fast internal oscillator
        logic slow;  // 31 kHz slow internal rc
        logic pll;   // selected pll output
    } opcs_tick_type;

    // reset values
    localparam opcs_trim_type TRIM_RST = 8'h00;
    localparam logic [2:0]    FREQ_RST = 3'h6;  // 4 MHz postscaler tap
    localparam opcs_cfg_type  CFG_RST  = 14'h0200;

    // timing
    localparam int CLK_NS   = 100;
    localparam int LOCK_NS  = 2000;
    localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_W   = 8;
    localparam logic [10:0] OST_TICKS = 11'h400;

    // whole block state
    typedef struct packed {
        opcs_trim_type     trim;
        logic [2:0]        freq_sel;
        opcs_cfg_type      cfg;
        logic [LOCK_W-1:0] lock_cnt;
        logic              locked;
        logic              on_pll;
        logic [2:0]        div_cnt;
        logic [7:0]        post_cnt;
        logic [3:0]        pre_cnt;
        logic              fix_half;
        logic              co_half;
        logic              second_oscillator_pin;
        logic              second_oscillator_pin_oe_n;
        logic              cpu_tick;
        logic              pll_en;
        logic              ref_tick;
        logic [10:0]       ost_cnt;
        logic              clk_ready;
        logic              rc_en;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
    } opcs_state_type;

endpackage

//--- hw/opcs_clock_select.sv
// clock select, divider, pll control and internal oscillator control
// Behaviour
// - cpu clock is source divided by 1, 2, 3 or 6 per divider select.
// - external clock modes have no start-up delay after reset or wake.
// - external clock mode drives second pin with input clock divided by 4.
// - external multiplied mode drives second pin with pll core clock divided by 4 once on the pll, with input clock divided by 4 before.
// - multiplied modes enable pll when soft enable set or config enable cleared.
// - fixed pll takes 4 MHz, gives 96 MHz, halved to 48 MHz core clock.
// - eight prescaler settings feed fixed pll from multiples of 4 MHz.
// - four-times pll multiplies 4 to 12 MHz input by four.
// - pll choice bit picks fixed pll or four-times pll.
// - fast 8 MHz oscillator drives clock directly or through postscaler.
// - fast internal oscillator may feed the pll.
// - slow rc runs when selected or any timer or monitor feature enabled.
// - frequency select picks fast direct, slow rc, or a postscaler tap.
// - trim write takes effect at once with no completion flag.
// - low frequency source bit chooses which oscillator gives 31 kHz.
// - modes without multiplier keep the pll off regardless of soft enable.
// - clock stays on prior source until pll ready, then switches itself.
// - source bit set gives fast oscillator over 256, clear gives slow rc.
// - trim value is six-bit two's complement offset around centre.
// - pll enabled by config bit is not stopped by clearing soft enable.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
module opcs_clock_select (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [7:0]              paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire opcs_pkg::opcs_tick_type src_ticks,
    input  wire logic                    wake_pulse,
    output logic                         cpu_clk_tick,
    output logic                         second_oscillator_pin_o,
    output logic                         second_oscillator_pin_oe_n,
    output logic                         pll_enable,
    output logic                         pll_four_times_sel,
    output logic                         pll_ref_tick,
    output logic      [5:0]              trim_code,
    output logic                         slow_rc_enable,
    output logic                         clock_ready
);
    import opcs_pkg::*;

    opcs_state_type s_ff;
    opcs_state_type nxt_s;

    // pll-capable modes
    function automatic logic is_mult(input opcs_mode_type m);
        is_mult = (m == INTERNAL_MULTIPLIED_MODE) || (m == INTERNAL_MULTIPLIED_CLKOUT_MODE)
               || (m == CRYSTAL_MULTIPLIED_MODE) || (m == EXT_CLOCK_MULTIPLIED_MODE);
    endfunction

    function automatic logic is_ext(input opcs_mode_type m);
        is_ext = (m == EXTERNAL_CLOCK_IN_MODE) || (m == EXT_CLOCK_MULTIPLIED_MODE);
    endfunction

    function automatic logic is_xtal(input opcs_mode_type m);
        is_xtal = (m == CRYSTAL_MODE) || (m == CRYSTAL_MULTIPLIED_MODE);
    endfunction

    function automatic logic is_int(input opcs_mode_type m);
        is_int = (m[2] == 1'b0);
    endfunction

    // cpu divider ratio
    function automatic logic [2:0] cpu_div(input logic [1:0] c);
        unique case (c)
            2'h0: cpu_div = 3'h1;
            2'h1: cpu_div = 3'h2;
            2'h2: cpu_div = 3'h3;
            2'h3: cpu_div = 3'h6;
        endcase
    endfunction

    // prescaler ratio: 4, 8, 12, 16, 20, 24, 40, 48 MHz inputs
    function automatic logic [3:0] pre_div(input logic [2:0] c);
        unique case (c)
            3'h0: pre_div = 4'h1;
            3'h1: pre_div = 4'h2;
            3'h2: pre_div = 4'h3;
            3'h3: pre_div = 4'h4;
            3'h4: pre_div = 4'h5;
            3'h5: pre_div = 4'h6;
            3'h6: pre_div = 4'hA;
            3'h7: pre_div = 4'hC;
        endcase
    endfunction

    logic       mult;
    logic       int_tick;
    logic       base_tick;
    logic       pll_in;
    logic       pll_core;
    logic       src_tick;
    logic       co_tick;
    logic [7:0] post_msk;
    logic [3:0] pdiv;
    logic [2:0] cdiv;

    // source selection, all from current state
    always_comb begin
        mult     = is_mult(s_ff.cfg.osc_mode);
        cdiv     = cpu_div(s_ff.cfg.cpu_clock_divider_select);
        pdiv     = pre_div(s_ff.cfg.pll_prescale_select);
        // each tap halves the rate: 125 kHz at code 1 up to 4 MHz at 6
        post_msk = 8'hFF >> ({1'b0, s_ff.freq_sel} + 4'h1);
        if (s_ff.freq_sel == 3'h0) begin
            int_tick = s_ff.trim.low_freq_source_select
                     ? (src_ticks.fast && (s_ff.post_cnt == 8'hFF))
                     : src_ticks.slow;
        end else begin
            int_tick = src_ticks.fast && ((s_ff.post_cnt & post_msk) == post_msk);
        end
        base_tick = is_int(s_ff.cfg.osc_mode) ? int_tick : src_ticks.prim;
        pll_in    = is_int(s_ff.cfg.osc_mode) ? src_ticks.fast : src_ticks.prim;
        // fixed pll output is halved, four-times pll is used as is
        pll_core  = s_ff.cfg.pll_choice_select ? src_ticks.pll
                  : (src_ticks.pll && s_ff.fix_half);
        src_tick  = s_ff.on_pll ? pll_core : base_tick;
        co_tick   = (s_ff.on_pll && s_ff.cfg.osc_mode == EXT_CLOCK_MULTIPLIED_MODE)
                  ? pll_core : src_ticks.prim;
    end

    // next state
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.pready  = 1'b0;
        nxt_s.pslverr = 1'b0;

        // apb setup phase loads read data so the access ends in one cycle
        if (psel && !penable) begin
            nxt_s.pready = 1'b1;
            unique case (paddr)
                ADDR_TRIM:   nxt_s.prdata = {24'h00_0000, s_ff.trim};
                ADDR_FREQ:   nxt_s.prdata = {29'h0000_0000, s_ff.freq_sel};
                ADDR_CFG:    nxt_s.prdata = {18'h0_0000, s_ff.cfg};
                ADDR_STATUS: nxt_s.prdata = {27'h000_0000, s_ff.clk_ready, s_ff.rc_en,
                                             s_ff.on_pll, s_ff.locked, s_ff.pll_en};
                default: begin
                    nxt_s.prdata  = 32'h0000_0000;
                    nxt_s.pslverr = 1'b1;
                end
            endcase
        end

        // writes land at the access edge; status is read-only
        if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr) begin
            unique case (paddr)
                ADDR_TRIM: nxt_s.trim     = pwdata[7:0];
                ADDR_FREQ: nxt_s.freq_sel = pwdata[2:0];
                ADDR_CFG:  nxt_s.cfg      = pwdata[13:0];
                default: ;
            endcase
        end

        // postscaler and fixed-pll halving counters
        if (src_ticks.fast) begin
            nxt_s.post_cnt = s_ff.post_cnt + 8'h01;
        end
        if (src_ticks.pll) begin
            nxt_s.fix_half = !s_ff.fix_half;
        end

        // in multiplied modes config enable cleared keeps the pll on whatever software writes to soft enable
        nxt_s.pll_en = mult && (s_ff.trim.multiplier_soft_enable
                     || !s_ff.cfg.multiplier_config_enable);

        // prescaler ahead of the fixed pll
        nxt_s.ref_tick = 1'b0;
        if (!s_ff.pll_en) begin
            nxt_s.pre_cnt = 4'h0;
        end else if (s_ff.cfg.pll_choice_select) begin
            nxt_s.ref_tick = pll_in;
        end else if (pll_in) begin
            // >= so a smaller ratio set mid-count cannot wrap round
            if (s_ff.pre_cnt >= pdiv - 4'h1) begin
                nxt_s.pre_cnt  = 4'h0;
                nxt_s.ref_tick = 1'b1;
            end else begin
                nxt_s.pre_cnt = s_ff.pre_cnt + 4'h1;
            end
        end

        // lock counter models the pll start-up time
        // follows the next enable so the core leaves the pll as it stops
        if (!nxt_s.pll_en) begin
            nxt_s.lock_cnt = '0;
            nxt_s.locked   = 1'b0;
        end else if (s_ff.lock_cnt == LOCK_W'(LOCK_CYC - 1)) begin
            nxt_s.locked = 1'b1;
        end else begin
            nxt_s.lock_cnt = s_ff.lock_cnt + 1'b1;
        end

        // switch onto the pll only at a divider period edge to avoid runt pulses
        if (!nxt_s.locked) begin
            nxt_s.on_pll = 1'b0;
        end else if (s_ff.div_cnt == 3'h0) begin
            nxt_s.on_pll = 1'b1;
        end

        // oscillator start-up: crystals wait, external clocks do not
        if (wake_pulse && is_xtal(s_ff.cfg.osc_mode)) begin
            nxt_s.ost_cnt   = OST_TICKS;
            nxt_s.clk_ready = 1'b0;
        end else begin
            if (src_ticks.prim && s_ff.ost_cnt != 11'h000) begin
                nxt_s.ost_cnt = s_ff.ost_cnt - 11'h001;
            end
            nxt_s.clk_ready = !is_xtal(s_ff.cfg.osc_mode)
                            || (s_ff.ost_cnt == 11'h000);
        end

        // cpu divider
        nxt_s.cpu_tick = 1'b0;
        if (s_ff.clk_ready && src_tick) begin
            if (s_ff.div_cnt >= cdiv - 3'h1) begin
                nxt_s.div_cnt  = 3'h0;
                nxt_s.cpu_tick = 1'b1;
            end else begin
                nxt_s.div_cnt = s_ff.div_cnt + 3'h1;
            end
        end

        // second pin toggles every other tick: a quarter of the rate
        if (is_ext(s_ff.cfg.osc_mode) && co_tick) begin
            nxt_s.co_half = !s_ff.co_half;
            if (s_ff.co_half) begin
                nxt_s.second_oscillator_pin = !s_ff.second_oscillator_pin;
            end
        end

        // pin direction registered so the port comes straight from a flop
        nxt_s.second_oscillator_pin_oe_n = !is_ext(s_ff.cfg.osc_mode);

        // slow rc runs when it is the clock or a supervisor needs it
        nxt_s.rc_en = (s_ff.cfg.feature_enables != 4'h0)
                    || (is_int(s_ff.cfg.osc_mode) && !s_ff.on_pll
                        && s_ff.freq_sel == 3'h0
                        && !s_ff.trim.low_freq_source_select);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff           <= '0;
            s_ff.trim      <= TRIM_RST;
            s_ff.freq_sel  <= FREQ_RST;
            s_ff.cfg       <= CFG_RST;
            s_ff.ost_cnt   <= OST_TICKS;
            s_ff.second_oscillator_pin_oe_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from state
    assign prdata             = s_ff.prdata;
    assign pready             = s_ff.pready;
    assign pslverr            = s_ff.pslverr;
    assign cpu_clk_tick       = s_ff.cpu_tick;
    assign second_oscillator_pin_o             = s_ff.second_oscillator_pin;
    assign second_oscillator_pin_oe_n          = s_ff.second_oscillator_pin_oe_n;
    assign pll_enable         = s_ff.pll_en;
    assign pll_four_times_sel = s_ff.cfg.pll_choice_select;
    assign pll_ref_tick       = s_ff.ref_tick;
    assign trim_code          = s_ff.trim.trim_value_field;  // no settle flag on purpose
    assign slow_rc_enable     = s_ff.rc_en;
    assign clock_ready        = s_ff.clk_ready;

    // checks
    AST_PLAIN_NO_PLL: assert property (@(posedge pclk) disable iff (!presetn)
        !is_mult(s_ff.cfg.osc_mode) && !is_mult($past(s_ff.cfg.osc_mode)) |-> !s_ff.pll_en)
        else $error("pll enabled in a mode without multiplier");

    AST_CFG_KEEPS_PLL: assert property (@(posedge pclk) disable iff (!presetn)
        is_mult(s_ff.cfg.osc_mode) && !s_ff.cfg.multiplier_config_enable
        && $stable(s_ff.cfg) |=> s_ff.pll_en)
        else $error("config-enabled pll dropped");

    AST_SOFT_EN: assert property (@(posedge pclk) disable iff (!presetn)
        is_mult(s_ff.cfg.osc_mode) && s_ff.trim.multiplier_soft_enable |=> s_ff.pll_en)
        else $error("soft enable ignored");

    AST_LOCK_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(s_ff.pll_en) |-> !s_ff.locked [*8])
        else $error("pll ready too early");

    AST_SWITCH_AFTER_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.on_pll |-> s_ff.locked && s_ff.pll_en)
        else $error("core on pll before ready");

    AST_EXT_NO_STARTUP: assert property (@(posedge pclk) disable iff (!presetn)
        is_ext(s_ff.cfg.osc_mode) && is_ext($past(s_ff.cfg.osc_mode)) |-> s_ff.clk_ready)
        else $error("start-up delay in external clock mode");

    AST_SECOND_OSCILLATOR_PIN_PACE: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(s_ff.second_oscillator_pin) |-> $past(co_tick) && $past(s_ff.co_half))
        else $error("second pin toggled off its quarter rate");

    AST_DIV_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.clk_ready && src_tick && s_ff.cfg.cpu_clock_divider_select == 2'h0
        |=> s_ff.cpu_tick)
        else $error("divide by one skipped a tick");

    AST_RC_FEATURE: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.cfg.feature_enables != 4'h0 |=> s_ff.rc_en)
        else $error("slow rc off while a feature needs it");

    AST_TRIM_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && pwrite && paddr == ADDR_TRIM
        |=> trim_code == $past(pwdata[5:0]))
        else $error("trim write not applied");

    AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("apb answer late");

    AST_REF_GATED: assert property (@(posedge pclk) disable iff (!presetn)
        !s_ff.pll_en |=> !s_ff.ref_tick)
        else $error("pll reference pulse while pll off");

    AST_OE_EXT: assert property (@(posedge pclk) disable iff (!presetn)
        is_ext(s_ff.cfg.osc_mode) && $stable(s_ff.cfg) |-> !second_oscillator_pin_oe_n)
        else $error("second pin not driven in external mode");

    AST_FIX_HALF: assert property (@(posedge pclk) disable iff (!presetn)
        s_ff.on_pll && !s_ff.cfg.pll_choice_select && !s_ff.fix_half
        |=> !s_ff.cpu_tick)
        else $error("fixed pll core tick not halved");

    COV_LOCK: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_ff.locked));
    COV_ON_PLL: cover property (@(posedge pclk) disable iff (!presetn) $rose(s_ff.on_pll));
    COV_SECOND_OSCILLATOR_PIN: cover property (@(posedge pclk) disable iff (!presetn)
        s_ff.on_pll && !second_oscillator_pin_oe_n && $changed(s_ff.second_oscillator_pin));
    COV_LOWFREQ: cover property (@(posedge pclk) disable iff (!presetn)
        s_ff.freq_sel == 3'h0 && s_ff.trim.low_freq_source_select && s_ff.cpu_tick);
    COV_WAKE_WAIT: cover property (@(posedge pclk) disable iff (!presetn) $fell(s_ff.clk_ready));

endmodule // opcs_clock_select

//--- verification/opcs_clock_select_test.sv
// self-checking bench for the clock select block
`timescale 1ns/10ps
module opcs_clock_select_test;
    import opcs_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, wake_pulse, pready, pslverr;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          cpu_clk_tick, second_oscillator_pin_o, second_oscillator_pin_oe_n, pll_enable, pll_four_times_sel;
    logic          pll_ref_tick, slow_rc_enable, clock_ready, er, osc_prev;
    logic [5:0]    trim_code;
    logic [15:0]   lfsr, r;
    opcs_tick_type src_ticks;
    int            n_fail, n_compared, cnt_cpu, cnt_ref, cnt_osc, d_cpu, d_ref, d_osc;

    opcs_clock_select i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_ticks(src_ticks), .wake_pulse(wake_pulse),
        .cpu_clk_tick(cpu_clk_tick), .second_oscillator_pin_o(second_oscillator_pin_o), .second_oscillator_pin_oe_n(second_oscillator_pin_oe_n),
        .pll_enable(pll_enable), .pll_four_times_sel(pll_four_times_sel),
        .pll_ref_tick(pll_ref_tick), .trim_code(trim_code),
        .slow_rc_enable(slow_rc_enable), .clock_ready(clock_ready)
    );

    // 10 MHz bus clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // free-running event counters; runs take deltas so no clearing race
    always @(posedge pclk) begin
        if (cpu_clk_tick === 1'b1) cnt_cpu <= cnt_cpu + 1;
        if (pll_ref_tick === 1'b1) cnt_ref <= cnt_ref + 1;
        if (second_oscillator_pin_o !== osc_prev) cnt_osc <= cnt_osc + 1;
        osc_prev <= second_oscillator_pin_o;
    end

    // repeatable random source, seed 25
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction

    // counts are phase dependent at the window edges, so allow one either way
    function automatic logic near(input int got, input int exp);
        return (got >= exp - 1) && (got <= exp + 1);
    endfunction

    function automatic logic [31:0] cfgw(input logic [3:0] f, input logic c, input logic s,
                                         input logic [2:0] p, input logic [1:0] v,
                                         input logic [2:0] m);
        return {18'h0_0000, f, c, s, p, v, m};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        chk("pready wait", 1, k == 1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk("prdata", exp, rd);
        chk("pslverr", 0, er);
    endtask

    // let registered outputs settle after the last write
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask

    // n one-cycle pulses on one source with random gaps
    task automatic run(input int b, input int n);
        int c0, r0, o0;
        c0 = cnt_cpu;
        r0 = cnt_ref;
        o0 = cnt_osc;
        repeat (n) begin
            @(posedge pclk);
            src_ticks <= opcs_tick_type'(4'h1 << b);
            @(posedge pclk);
            src_ticks <= '0;
            if (rnd() % 2 == 1) @(posedge pclk);
        end
        repeat (4) @(posedge pclk);
        d_cpu = cnt_cpu - c0;
        d_ref = cnt_ref - r0;
        d_osc = cnt_osc - o0;
    endtask

    task automatic wake();
        @(posedge pclk);
        wake_pulse <= 1'b1;
        @(posedge pclk);
        wake_pulse <= 1'b0;
        settle();
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // hang guard, well beyond the roughly 15k cycles the tests need
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        $display("[ERR] watchdog expected done seen hang");
        report_and_stop();
    end

    // main sequence
    initial begin
        int i;
        int dv[4];
        int pv[8];
        dv = '{1, 2, 3, 6};
        pv = '{1, 2, 3, 4, 5, 6, 10, 12};
        {presetn, psel, penable, pwrite, wake_pulse, osc_prev} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        src_ticks = '0;
        lfsr = 16'h0019;
        {n_fail, n_compared, cnt_cpu, cnt_ref, cnt_osc} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_TRIM, 32'h0000_0000);
        rdchk(ADDR_FREQ, 32'h0000_0006);
        rdchk(ADDR_CFG, 32'h0000_0200);
        rdchk(ADDR_STATUS, 32'h0000_0010);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        apb(1'b1, ADDR_STATUS, 32'h0000_001F);
        rdchk(ADDR_STATUS, 32'h0000_0010);
        $display("test reset_and_bus done");
        // trim corners then random values
        for (i = 0; i < 5; i++) begin
            r = (i == 0) ? 16'h001F : (i == 1) ? 16'h0020 : rnd();
            apb(1'b1, ADDR_TRIM, {26'h000_0000, r[5:0]});
            settle();
            chk("trim_code", r[5:0], trim_code);
            rdchk(ADDR_TRIM, {26'h000_0000, r[5:0]});
        end
        apb(1'b1, ADDR_TRIM, 32'h0000_0000);
        $display("test trim done");
        // postscaler taps /64 down to /2
        for (i = 1; i < 7; i++) begin
            apb(1'b1, ADDR_FREQ, i);
            run(2, 256);
            chk("postscale ticks", 1, near(d_cpu, 2 << i));
        end
        apb(1'b1, ADDR_FREQ, 32'h0000_0007);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, 3'h0, i[1:0], INTERNAL_DIRECT_MODE));
            run(2, 120);
            chk("cpu divide", 1, near(d_cpu, 120 / dv[i]));
        end
        apb(1'b1, ADDR_CFG, 32'h0000_0200);
        $display("test divide done");
        // 31 kHz source: slow rc direct, then fast over 256
        apb(1'b1, ADDR_FREQ, 32'h0000_0000);
        settle();
        chk("rc enable", 1, slow_rc_enable);
        run(1, 8);
        chk("slow ticks", 1, near(d_cpu, 8));
        apb(1'b1, ADDR_TRIM, 32'h0000_0080);
        settle();
        chk("rc enable", 0, slow_rc_enable);
        run(1, 8);
        chk("slow ignored", 0, d_cpu);
        run(2, 1024);
        chk("fast over 256", 1, near(d_cpu, 4));
        apb(1'b1, ADDR_TRIM, 32'h0000_0000);
        apb(1'b1, ADDR_FREQ, 32'h0000_0006);
        for (i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_CFG, cfgw(4'h1 << i, 1'b1, 1'b0, 3'h0, 2'h0, 3'h0));
            settle();
            chk("rc enable feature", i < 4, slow_rc_enable);
        end
        $display("test low_freq done");
        // soft enable in every mode
        apb(1'b1, ADDR_TRIM, 32'h0000_0040);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, i[0], 3'h0, 2'h0, i[2:0]));
            settle();
            chk("pll_enable", i == 2 || i == 3 || i == 5 || i == 7, pll_enable);
            chk("four times sel", i[0], pll_four_times_sel);
            chk("second_oscillator_pin oe_n", i < 6, second_oscillator_pin_oe_n);
        end
        apb(1'b1, ADDR_TRIM, 32'h0000_0000);
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b0, 1'b0, 3'h0, 2'h0, CRYSTAL_MULTIPLIED_MODE));
        settle();
        chk("config forced pll", 1, pll_enable);
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b0, 1'b0, 3'h0, 2'h0, CRYSTAL_MODE));
        settle();
        chk("no-mult mode pll", 0, pll_enable);
        $display("test pll_enable done");
        // start-up wait: crystal waits, external clock does not
        wake();
        chk("crystal wait", 0, clock_ready);
        run(3, 1020);
        chk("crystal wait", 0, clock_ready);
        run(3, 8);
        chk("crystal ready", 1, clock_ready);
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, 3'h0, 2'h0, EXTERNAL_CLOCK_IN_MODE));
        wake();
        chk("ext no wait", 1, clock_ready);
        run(3, 40);
        chk("ext cpu ticks", 1, near(d_cpu, 40));
        chk("second_oscillator_pin quarter", 1, near(d_osc, 20));
        $display("test startup done");
        // pll path: refs gated off, prescaler table, then lock and switch
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, 3'h0, 2'h0, EXT_CLOCK_MULTIPLIED_MODE));
        run(3, 12);
        chk("ref while off", 0, d_ref);
        apb(1'b1, ADDR_TRIM, 32'h0000_0040);
        for (i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, i[2:0], 2'h0, 3'h7));
            run(3, 120);
            chk("prescale refs", 1, near(d_ref, 120 / pv[i]));
        end
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b1, 3'h2, 2'h0, 3'h7));
        run(3, 30);
        chk("four times raw", 1, near(d_ref, 30));
        apb(1'b1, ADDR_TRIM, 32'h0000_0000);
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, 3'h0, 2'h0, 3'h7));
        apb(1'b1, ADDR_TRIM, 32'h0000_0040);
        rdchk(ADDR_STATUS, 32'h0000_0011);
        repeat (LOCK_CYC + 10) @(posedge pclk);
        rdchk(ADDR_STATUS, 32'h0000_0017);
        run(3, 20);
        chk("prim after switch", 0, d_cpu);
        run(0, 40);
        chk("pll core ticks", 1, near(d_cpu, 20));
        chk("second_oscillator_pin pll quarter", 1, near(d_osc, 10));
        apb(1'b1, ADDR_CFG, cfgw(4'h0, 1'b1, 1'b0, 3'h1, 2'h0, INTERNAL_MULTIPLIED_MODE));
        run(2, 40);
        chk("fast into pll", 1, near(d_ref, 20));
        $display("test pll done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_STATUS, 32'h0000_0010);
        $display("test reset_again done");
        report_and_stop();
    end
endmodule // opcs_clock_select_test
